/* dorus_consts.vh */
`ifndef DORUS_CONSTS_VH
`define DORUS_CONSTS_VH

// register byte offsets
`define DORUS_OFF_CH1_READBACK 12'h02c
`define DORUS_OFF_CH2_READBACK 12'h030
`define DORUS_OFF_STATUS 12'h034
`define DORUS_OFF_IRQ_MASK 12'h038

// address decode width
`define DORUS_ADDR_W 12

// field positions and widths
`define DORUS_VALUE_W 12
`define DORUS_CH1_UDR_BIT 13
`define DORUS_CH2_UDR_BIT 29

// reset values
`define DORUS_RST_READBACK 32'h0000_0000
`define DORUS_RST_STATUS 32'h0000_0000
`define DORUS_RST_MASK 32'h0000_0000

// bus responses
`define DORUS_RESP_OKAY 2'b00
`define DORUS_RESP_SLVERR 2'b10

`endif

/* dorus_underrun_det.v */
`timescale 1ns/1ps
`default_nettype none

// one converter channel: tracks the pending transfer request and flags a
// trigger that arrives before the previous request was served
module dorus_underrun_det (
    input wire aclk,
    input wire aresetn,
    input wire trigger,
    input wire dma_enable,
    input wire dma_ack,
    input wire flag_set,
    output reg dma_request,
    output reg underrun_event
);

    // a raised flag parks the channel: no new requests until software
    // clears it, so one stall is reported once and not per trigger
    always @(posedge aclk) begin
        if (!aresetn) begin
            dma_request <= 1'b0;
            underrun_event <= 1'b0;
        end else begin
            underrun_event <= 1'b0;
            if (trigger && dma_enable && !flag_set) begin
                if (dma_request && !dma_ack) begin
                    underrun_event <= 1'b1; // trigger outran the controller
                    dma_request <= 1'b0;
                end else begin
                    dma_request <= 1'b1;
                end
            end else if (dma_ack || !dma_enable || flag_set) begin
                dma_request <= 1'b0;
            end
        end
    end

endmodule // dorus_underrun_det

`default_nettype wire

/* dorus_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "dorus_consts.vh"

// What this block does
// - channel one output value readable at 0x2c
// - channel two output value readable at 0x30
// - underrun flags set by hardware, write-one clears
// - bit 29 flags channel two transfer underrun
// - bit 13 flags channel one transfer underrun
// - status and mask read zero after reset, readbacks track the output values
module dorus_top #(
    parameter VALUE_W = `DORUS_VALUE_W
) (
    input wire aclk,
    input wire aresetn,
    // register bus, write address
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // converter datapath: values now driving each output
    input wire [VALUE_W-1:0] ch1_output_value,
    input wire [VALUE_W-1:0] ch2_output_value,
    // selected conversion triggers, one-cycle pulses
    input wire ch1_trigger,
    input wire ch2_trigger,
    // transfer enables from the control logic
    input wire ch1_dma_enable,
    input wire ch2_dma_enable,
    // transfer controller side
    input wire ch1_dma_ack,
    input wire ch2_dma_ack,
    output wire ch1_dma_request,
    output wire ch2_dma_request,
    // interrupt, high while an unmasked flag stands
    output reg irq
);

    localparam AW = `DORUS_ADDR_W;
    localparam [31:0] RST_MASK = `DORUS_RST_MASK;

    // registered copies of the output values
    reg [VALUE_W-1:0] ch1_value_q;
    reg [VALUE_W-1:0] ch2_value_q;

    // sticky flags and their mask
    reg ch1_transfer_underrun_flag;
    reg ch2_transfer_underrun_flag;
    reg ch1_irq_mask;
    reg ch2_irq_mask;

    // write channel holding state
    reg aw_held;
    reg w_held;
    reg [AW-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // detector events
    wire ch1_underrun_event;
    wire ch2_underrun_event;

    // write decode
    wire wr_fire;
    wire wr_hit_status;
    wire wr_hit_mask;
    wire wr_hit_readback;
    wire wr_mapped;
    wire ch1_clear;
    wire ch2_clear;

    // read decode
    wire rd_fire;
    wire [AW-1:0] rd_addr;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;

    // status and mask words as software sees them
    wire [31:0] status_word;
    wire [31:0] mask_word;

    // ---------------------------------------------------------------
    // per-channel underrun detection
    // ---------------------------------------------------------------

    // channel one detector
    dorus_underrun_det u_ch1_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(ch1_trigger),
        .dma_enable(ch1_dma_enable),
        .dma_ack(ch1_dma_ack),
        .flag_set(ch1_transfer_underrun_flag),
        .dma_request(ch1_dma_request),
        .underrun_event(ch1_underrun_event)
    );

    // channel two detector
    dorus_underrun_det u_ch2_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(ch2_trigger),
        .dma_enable(ch2_dma_enable),
        .dma_ack(ch2_dma_ack),
        .flag_set(ch2_transfer_underrun_flag),
        .dma_request(ch2_dma_request),
        .underrun_event(ch2_underrun_event)
    );

    // ---------------------------------------------------------------
    // output value capture
    // ---------------------------------------------------------------

    // one flop stage so a read never samples a changing datapath word
    always @(posedge aclk) begin
        if (!aresetn) begin
            ch1_value_q <= {VALUE_W{1'b0}};
            ch2_value_q <= {VALUE_W{1'b0}};
        end else begin
            ch1_value_q <= ch1_output_value;
            ch2_value_q <= ch2_output_value;
        end
    end

    // ---------------------------------------------------------------
    // write address and data channels
    // ---------------------------------------------------------------

    // each channel stalls only while its own beat is held
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    // address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= {AW{1'b0}};
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr[AW-1:0];
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // commit once both halves are in and the last answer has gone
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // write decode; word aligned, low address bits ignored
    assign wr_hit_status = ({aw_addr_q[AW-1:2], 2'b00} == `DORUS_OFF_STATUS);
    assign wr_hit_mask = ({aw_addr_q[AW-1:2], 2'b00} == `DORUS_OFF_IRQ_MASK);
    assign wr_hit_readback = ({aw_addr_q[AW-1:2], 2'b00} == `DORUS_OFF_CH1_READBACK)
        || ({aw_addr_q[AW-1:2], 2'b00} == `DORUS_OFF_CH2_READBACK);
    assign wr_mapped = wr_hit_status || wr_hit_mask || wr_hit_readback;

    // a one in a flag position clears it, only with its byte lane on
    assign ch1_clear = wr_fire && wr_hit_status && w_strb_q[1]
        && w_data_q[`DORUS_CH1_UDR_BIT];
    assign ch2_clear = wr_fire && wr_hit_status && w_strb_q[3]
        && w_data_q[`DORUS_CH2_UDR_BIT];

    // write response; readback writes are accepted and dropped
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DORUS_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `DORUS_RESP_OKAY : `DORUS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // sticky underrun flags
    // ---------------------------------------------------------------

    // set wins over a clear in the same cycle so no event is lost
    always @(posedge aclk) begin
        if (!aresetn) begin
            ch1_transfer_underrun_flag <= 1'b0;
            ch2_transfer_underrun_flag <= 1'b0;
        end else begin
            if (ch1_underrun_event) begin
                ch1_transfer_underrun_flag <= 1'b1;
            end else if (ch1_clear) begin
                ch1_transfer_underrun_flag <= 1'b0;
            end
            if (ch2_underrun_event) begin
                ch2_transfer_underrun_flag <= 1'b1;
            end else if (ch2_clear) begin
                ch2_transfer_underrun_flag <= 1'b0;
            end
        end
    end

    // interrupt mask, same layout as the status word
    always @(posedge aclk) begin
        if (!aresetn) begin
            ch1_irq_mask <= RST_MASK[`DORUS_CH1_UDR_BIT];
            ch2_irq_mask <= RST_MASK[`DORUS_CH2_UDR_BIT];
        end else if (wr_fire && wr_hit_mask) begin
            if (w_strb_q[1]) begin
                ch1_irq_mask <= w_data_q[`DORUS_CH1_UDR_BIT];
            end
            if (w_strb_q[3]) begin
                ch2_irq_mask <= w_data_q[`DORUS_CH2_UDR_BIT];
            end
        end
    end

    // registered level, one cycle behind the flag
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (ch1_transfer_underrun_flag && ch1_irq_mask)
                || (ch2_transfer_underrun_flag && ch2_irq_mask);
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------

    // reserved bits read zero
    assign status_word = {2'b00, ch2_transfer_underrun_flag, 15'h0000,
        ch1_transfer_underrun_flag, 13'h0000};
    assign mask_word = {2'b00, ch2_irq_mask, 15'h0000,
        ch1_irq_mask, 13'h0000};

    // one read in flight; a new address waits until rdata is taken
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
    assign rd_addr = s_axi_araddr[AW-1:0];

    // read mux; unmapped words answer zero with an error
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `DORUS_RESP_OKAY;
        case ({rd_addr[AW-1:2], 2'b00})
            `DORUS_OFF_CH1_READBACK: begin
                next_rdata = {{(32-VALUE_W){1'b0}}, ch1_value_q};
            end
            `DORUS_OFF_CH2_READBACK: begin
                next_rdata = {{(32-VALUE_W){1'b0}}, ch2_value_q};
            end
            `DORUS_OFF_STATUS: begin
                next_rdata = status_word;
            end
            `DORUS_OFF_IRQ_MASK: begin
                next_rdata = mask_word;
            end
            default: begin
                next_rresp = `DORUS_RESP_SLVERR;
            end
        endcase
    end

    // read data come from flops, held until rready
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DORUS_RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // dorus_top

`default_nettype wire

/* dorus_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none

// transfer controller stand-in: serves a pending request after delay cycles
module dorus_dma_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic request,
    input wire logic [3:0] delay,
    output logic ack
);
    logic [3:0] wait_cnt;

    // a large delay starves the channel, which is how underruns are provoked
    always @(posedge aclk) begin
        if (!aresetn || !request || ack) begin
            ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt == delay) begin
            ack <= 1'b1; // one-cycle service pulse
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // dorus_dma_model

`default_nettype wire

/* dorus_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dorus_consts.vh"

module dorus_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic ch1_trigger,
    input wire logic ch2_trigger,
    input wire logic ch1_dma_enable,
    input wire logic ch2_dma_enable,
    input wire logic ch1_dma_ack,
    input wire logic ch2_dma_ack,
    input wire logic ch1_dma_request,
    input wire logic ch2_dma_request,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // trigger landing on an unserved request
    sequence s_udr1;
        ch1_dma_enable && ch1_dma_request && ch1_trigger && !ch1_dma_ack;
    endsequence
    sequence s_udr2;
        ch2_dma_enable && ch2_dma_request && ch2_trigger && !ch2_dma_ack;
    endsequence

    rst_clear_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid
        && !s_axi_rvalid && !ch1_dma_request && !ch2_dma_request) else $error("reset state wrong");
    rd1_upper_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[11:0] == `DORUS_OFF_CH1_READBACK |=> s_axi_rvalid
        && s_axi_rdata[31:12] == 20'h0) else $error("readback one upper bits set");
    rd2_upper_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[11:0] == `DORUS_OFF_CH2_READBACK |=> s_axi_rvalid
        && s_axi_rdata[31:12] == 20'h0) else $error("readback two upper bits set");
    udr1_drop_a: assert property (s_udr1 |=> !ch1_dma_request ##1 !ch1_dma_request)
        else $error("channel one underrun not taken");
    udr2_drop_a: assert property (s_udr2 |=> !ch2_dma_request ##1 !ch2_dma_request)
        else $error("channel two underrun not taken");
    sticky_irq_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
        else $error("flag dropped without a write");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule // dorus_checker

bind dorus_top dorus_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .ch1_trigger(ch1_trigger),
    .ch2_trigger(ch2_trigger), .ch1_dma_enable(ch1_dma_enable), .ch2_dma_enable(ch2_dma_enable),
    .ch1_dma_ack(ch1_dma_ack), .ch2_dma_ack(ch2_dma_ack), .ch1_dma_request(ch1_dma_request),
    .ch2_dma_request(ch2_dma_request), .irq(irq));

`default_nettype wire

/* dorus_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dorus_consts.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module dorus_tb_top;
    logic aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, ch1_req, ch2_req, ch1_ack, ch2_ack;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] ch1_val = 0, ch2_val = 0;
    logic ch1_trg = 0, ch2_trg = 0, ch1_en = 0, ch2_en = 0;
    logic [3:0] dly = 0;
    int err_count = 0, checks_done = 0, cycles = 0;

    dorus_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ch1_output_value(ch1_val), .ch2_output_value(ch2_val), .ch1_trigger(ch1_trg),
        .ch2_trigger(ch2_trg), .ch1_dma_enable(ch1_en), .ch2_dma_enable(ch2_en),
        .ch1_dma_ack(ch1_ack), .ch2_dma_ack(ch2_ack), .ch1_dma_request(ch1_req),
        .ch2_dma_request(ch2_req), .irq(irq));
    dorus_dma_model u_dma1 (.aclk(aclk), .aresetn(aresetn), .request(ch1_req), .delay(dly),
        .ack(ch1_ack));
    dorus_dma_model u_dma2 (.aclk(aclk), .aresetn(aresetn), .request(ch2_req), .delay(dly),
        .ack(ch2_ack));

    // 50 ns period
    initial begin
        forever #25 aclk = ~aclk;
    end

    task complete_run;
        $display("err_count=%0d checks_done=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // handshakes decided at the falling edge, acted on at the next rising edge
    task wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        `CHK(r, er)
    endtask

    task rd_chk(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        while (!v) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        `CHK(d, ed)
        `CHK(r, er)
    endtask

    // one-cycle trigger pulse on the chosen channel
    task trig(input int ch);
        @(posedge aclk);
        if (ch == 1) ch1_trg <= 1'b1;
        else ch2_trg <= 1'b1;
        @(posedge aclk);
        ch1_trg <= 1'b0;
        ch2_trg <= 1'b0;
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run;
        end
    end

    initial begin
        logic [31:0] bit_v;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`DORUS_OFF_CH1_READBACK, 32'h0, `DORUS_RESP_OKAY);
        rd_chk(`DORUS_OFF_CH2_READBACK, 32'h0, `DORUS_RESP_OKAY);
        rd_chk(`DORUS_OFF_STATUS, 32'h0, `DORUS_RESP_OKAY);
        ch1_val <= 12'habc;
        ch2_val <= 12'h5a3;
        rd_chk(`DORUS_OFF_CH1_READBACK, 32'h0000_0abc, `DORUS_RESP_OKAY);
        rd_chk(`DORUS_OFF_CH2_READBACK, 32'h0000_05a3, `DORUS_RESP_OKAY);
        wr_chk(`DORUS_OFF_CH1_READBACK, 32'hffff_ffff, `DORUS_RESP_OKAY);
        rd_chk(`DORUS_OFF_CH1_READBACK, 32'h0000_0abc, `DORUS_RESP_OKAY);
        rd_chk(32'h3c, 32'h0, `DORUS_RESP_SLVERR);
        wr_chk(32'h3c, 32'hffff_ffff, `DORUS_RESP_SLVERR);
        // disabled channel ignores its trigger
        trig(1);
        @(negedge aclk);
        `CHK(ch1_req, 1'b0)
        // inputs move only just after a rising edge
        @(posedge aclk);
        ch1_en <= 1'b1;
        ch2_en <= 1'b1;
        wr_chk(`DORUS_OFF_IRQ_MASK, 32'h0000_2000, `DORUS_RESP_OKAY);
        // prompt service keeps the flags clear
        repeat (4) begin
            trig(1);
            trig(2);
            repeat (3) @(posedge aclk);
        end
        rd_chk(`DORUS_OFF_STATUS, 32'h0, `DORUS_RESP_OKAY);
        dly <= 4'hf;
        // starved service: second trigger lands on an unserved request
        for (int ch = 1; ch <= 2; ch++) begin
            bit_v = 32'h1 << ((ch == 1) ? `DORUS_CH1_UDR_BIT : `DORUS_CH2_UDR_BIT);
            trig(ch);
            repeat (2) @(posedge aclk);
            trig(ch);
            repeat (4) @(posedge aclk);
            rd_chk(`DORUS_OFF_STATUS, bit_v, `DORUS_RESP_OKAY);
            @(negedge aclk);
            `CHK(irq, (ch == 1)) // only channel one unmasked
            wr_chk(`DORUS_OFF_STATUS, 32'h0, `DORUS_RESP_OKAY);
            rd_chk(`DORUS_OFF_STATUS, bit_v, `DORUS_RESP_OKAY);
            wr_chk(`DORUS_OFF_STATUS, bit_v, `DORUS_RESP_OKAY);
            rd_chk(`DORUS_OFF_STATUS, 32'h0, `DORUS_RESP_OKAY);
            @(negedge aclk);
            `CHK(irq, 1'b0)
        end
        // raise a flag again so the mid-run reset has something to clear
        trig(1);
        repeat (2) @(posedge aclk);
        trig(1);
        repeat (4) @(posedge aclk);
        rd_chk(`DORUS_OFF_STATUS, 32'h0000_2000, `DORUS_RESP_OKAY);
        // second reset in mid-run clears flag and mask
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`DORUS_OFF_IRQ_MASK, 32'h0, `DORUS_RESP_OKAY);
        rd_chk(`DORUS_OFF_STATUS, 32'h0, `DORUS_RESP_OKAY);
        complete_run;
    end
endmodule // dorus_tb_top

`default_nettype wire
